// >>> shared/rcf_params.svh
`ifndef RCF_PARAMS_SVH
`define RCF_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RCF_OFS_SEC        4'h0
`define RCF_OFS_MIN        4'h1
`define RCF_OFS_HOUR       4'h2
`define RCF_OFS_WDAY       4'h3
`define RCF_OFS_MDAY       4'h4
`define RCF_OFS_MON        4'h5
`define RCF_OFS_YEAR       4'h6
`define RCF_OFS_TRIM       4'h7
`define RCF_OFS_FLAGS      4'hF
// ----------------------------------------
// Field positions and writable masks
// ----------------------------------------
`define RCF_BIT_PFLAG      2
`define RCF_BIT_CENT       7
`define RCF_BIT_PM         5
`define RCF_TRIM_DIR       6
`define RCF_MASK_SEC       8'h7F
`define RCF_MASK_MIN       `RCF_MASK_SEC
`define RCF_MASK_HOUR      8'h3F
`define RCF_MASK_MDAY      `RCF_MASK_HOUR
`define RCF_MASK_WDAY      8'h07
`define RCF_MASK_MON       8'h1F
`define RCF_MASK_TRIM      8'h7F
// ----------------------------------------
// Counter limits, BCD
// ----------------------------------------
`define RCF_BCD_NINE       4'h9
`define RCF_ZERO           8'h00
`define RCF_FIRST          8'h01
`define RCF_SEC_LAST       8'h59
`define RCF_H24_LAST       8'h23
`define RCF_H12_LAST       8'h31
`define RCF_H12_ONE        5'h01
`define RCF_H12_ELEVEN     5'h11
`define RCF_H12_TWELVE     5'h12
`define RCF_WDAY_LAST      8'h06
`define RCF_FEB            8'h02
`define RCF_APR            8'h04
`define RCF_JUN            8'h06
`define RCF_SEP            8'h09
`define RCF_NOV            8'h11
`define RCF_DEC            8'h12
`define RCF_DAYS_31        8'h31
`define RCF_DAYS_30        8'h30
`define RCF_DAYS_29        8'h29
`define RCF_DAYS_28        8'h28
`define RCF_YEAR_LAST      8'h99
`define RCF_TRIM_S20       8'h20
`define RCF_TRIM_S40       8'h40
// ----------------------------------------
// Timing
// ----------------------------------------
`define RCF_OSC_HZ         32768
`define RCF_TICKS_PER_SEC  16'h8000
`define RCF_ALARM_DELAY_NS 61000
`define RCF_ALARM_DELAY_CYC \
	(`RCF_ALARM_DELAY_NS * `RCF_OSC_HZ / 1000000000)
`endif

// >>> shared/rcf_pkg.sv
`default_nettype none
package rcf_pkg;
	// Time and calendar counters, one BCD byte each, century one bit
	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] wday;
		logic [7:0] mday;
		logic [7:0] mon;
		logic       cent;
		logic [7:0] year;
	} rcf_time_s;
	// Everything the register side reads
	typedef struct packed {
		rcf_time_s  t;
		logic [7:0] trim;
		logic [2:0] flags;
	} rcf_snap_s;
	// Register side handshake states
	typedef enum logic [1:0] {
		RCF_ST_IDLE = 2'b01,
		RCF_ST_WAIT = 2'b10
	} rcf_hs_e;
endpackage
`default_nettype wire

// >>> shared/rcf_cal_if.sv
`timescale 1ns/100ps
`default_nettype none
// Current time in, time one second later out
interface rcf_cal_if;
	logic                h24;
	rcf_pkg::rcf_time_s  cur;
	rcf_pkg::rcf_time_s  nxt;
	modport core (output h24, output cur, input nxt);
	modport step (input h24, input cur, output nxt);
endinterface
`default_nettype wire

// >>> logic/rcf_cal_step.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcf_params.svh"
module rcf_cal_step (
	// Calendar carrier
	rcf_cal_if.step cal
);
	// BCD increment of one byte
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == `RCF_BCD_NINE)
			return {v[7:4] + 4'h1, 4'h0};
		return {v[7:4], v[3:0] + 4'h1};
	endfunction

	// ----------------------------------------
	// Carry chain, all in one tick
	// ----------------------------------------
	wire       s_wrap = cal.cur.sec == `RCF_SEC_LAST;
	wire       m_wrap = s_wrap && cal.cur.min == `RCF_SEC_LAST;
	wire [4:0] h12    = cal.cur.hour[4:0];
	wire       pm     = cal.cur.hour[`RCF_BIT_PM];
	wire       h_last = cal.h24 ? cal.cur.hour == `RCF_H24_LAST
		: cal.cur.hour == `RCF_H12_LAST;
	wire       d_car  = m_wrap && h_last;
	// Twelve-hour stepping with PM in bit five
	wire [7:0] h12_inc = (h12 == `RCF_H12_TWELVE) ?
		{2'b00, pm, `RCF_H12_ONE} :
		(h12 == `RCF_H12_ELEVEN) ? {2'b00, ~pm, `RCF_H12_TWELVE} :
		bcd_inc(cal.cur.hour);
	wire [7:0] h24_inc = h_last ? `RCF_ZERO : bcd_inc(cal.cur.hour);
	// Leap year: BCD year divisible by four
	wire       leap = cal.cur.year[4] ? cal.cur.year[1:0] == 2'b10
		: cal.cur.year[1:0] == 2'b00;
	wire       short_mon = cal.cur.mon == `RCF_APR ||
		cal.cur.mon == `RCF_JUN || cal.cur.mon == `RCF_SEP ||
		cal.cur.mon == `RCF_NOV;
	wire [7:0] m_days = (cal.cur.mon == `RCF_FEB) ?
		(leap ? `RCF_DAYS_29 : `RCF_DAYS_28) :
		short_mon ? `RCF_DAYS_30 : `RCF_DAYS_31;
	wire       d_wrap = d_car && cal.cur.mday == m_days;
	wire       mo_wrap = d_wrap && cal.cur.mon == `RCF_DEC;
	wire       y_wrap = mo_wrap && cal.cur.year == `RCF_YEAR_LAST;
	wire       w_last = cal.cur.wday == `RCF_WDAY_LAST;

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	assign cal.nxt.sec  = s_wrap ? `RCF_ZERO
		: bcd_inc(cal.cur.sec);
	assign cal.nxt.min  = !s_wrap ? cal.cur.min
		: m_wrap ? `RCF_ZERO : bcd_inc(cal.cur.min);
	assign cal.nxt.hour = !m_wrap ? cal.cur.hour
		: cal.h24 ? h24_inc : h12_inc;
	assign cal.nxt.wday = !d_car ? cal.cur.wday
		: w_last ? `RCF_ZERO : cal.cur.wday + 8'h01;
	assign cal.nxt.mday = !d_car ? cal.cur.mday
		: d_wrap ? `RCF_FIRST : bcd_inc(cal.cur.mday);
	assign cal.nxt.mon  = !d_wrap ? cal.cur.mon
		: mo_wrap ? `RCF_FIRST : bcd_inc(cal.cur.mon);
	assign cal.nxt.year = !mo_wrap ? cal.cur.year
		: y_wrap ? `RCF_ZERO : bcd_inc(cal.cur.year);
	assign cal.nxt.cent = cal.cur.cent ^ y_wrap;
endmodule
`default_nettype wire

// >>> logic/rcf_rtc_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcf_params.svh"

// What this block does
// - Periodic flag reads one while its pin low
// - Level mode: writing zero clears periodic flag
// - Alarm flag sets about 61us after match
// - Writing zero clears alarm flag, releases pin
// - Disabled alarm reads its flag as zero
// - Seconds count 00..59 BCD, carry minutes
// - Minutes count 00..59 BCD, carry hours
// - Hours carry into day at day end
// - Seconds write clears the sub-second prescaler
// - Weekday advances by one per day carry
// - Weekday counts modulo seven, 0 to 6
// - Day of month wraps at month length
// - Month counts 1..12, carries into year
// - Year 00..99, multiples of four leap
// - Century bit toggles on year wrap
// - One second is 32768 oscillator cycles
// - Trim only in seconds 00, 20, 40
// - Trim write activates, skips current boundary
// - Trim lengthens by twice (magnitude - 1), shortens by twice (64 - magnitude)
// - Magnitude bits five to one zero: none
// - Twelve-hour midnight 12, noon 32, PM bit5
// - Oscillator halt clears the trim register
module rcf_rtc_core (
	// Clocks and reset
	input  wire logic       mclk_in,
	input  wire logic       osc_clk_in,
	input  wire logic       sys_rst_in,
	// Register port, main clock
	input  wire logic [3:0] reg_addr_in,
	input  wire logic       reg_wr_in,
	input  wire logic [7:0] reg_wdata_in,
	output logic            reg_ready_out,
	output logic [7:0]      reg_rdata_out,
	// Modes and events, oscillator clock
	input  wire logic       hour24_mode_in,
	input  wire logic       periodic_level_mode_in,
	input  wire logic       periodic_assert_in,
	input  wire logic       weekly_alarm_enable_in,
	input  wire logic       daily_alarm_enable_in,
	input  wire logic       weekly_alarm_match_in,
	input  wire logic       daily_alarm_match_in,
	// Halt detector, asynchronous
	input  wire logic       osc_halt_flag_in,
	// Interrupt pins, active low
	output logic            periodic_irq_pin_n_out,
	output logic            weekly_alarm_pin_n_out,
	output logic            daily_alarm_pin_n_out
);
	// ----------------------------------------
	// Constants
	// ----------------------------------------
	localparam rcf_pkg::rcf_time_s TIME_RST = '{
		sec:  `RCF_ZERO,
		min:  `RCF_ZERO,
		hour: `RCF_ZERO,
		wday: `RCF_ZERO,
		mday: `RCF_FIRST,
		mon:  `RCF_FIRST,
		cent: 1'b0,
		year: `RCF_ZERO
	};
	localparam logic [1:0] ALM_DLY = 2'(`RCF_ALARM_DELAY_CYC);
	localparam logic [15:0] CNT_PLAIN = `RCF_TICKS_PER_SEC - 16'h0001;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	// Main clock side
	rcf_pkg::rcf_hs_e   hs_reg;
	rcf_pkg::rcf_hs_e   hs_next;
	logic [3:0]         hold_addr_reg;
	logic [7:0]         hold_data_reg;
	logic               hold_wr_reg;
	logic               req_tgl_reg;
	logic               ack_s1_reg;
	logic               ack_s2_reg;
	logic               ack_seen_reg;
	rcf_pkg::rcf_snap_s snap_m_reg;
	logic [7:0]         rdata_reg;
	logic [7:0]         rd_mux;
	// Oscillator side
	logic               req_s1_reg;
	logic               req_s2_reg;
	logic               req_s3_reg;
	logic               halt_s1_reg;
	logic               halt_s2_reg;
	logic               halt_s3_reg;
	rcf_pkg::rcf_time_s time_reg;
	rcf_pkg::rcf_time_s time_next;
	rcf_pkg::rcf_time_s time_base;
	logic [15:0]        pre_reg;
	logic [15:0]        pre_next;
	logic [7:0]         trim_reg;
	logic [7:0]         trim_next;
	logic               trim_on_reg;
	logic               trim_on_next;
	logic               trim_skip_reg;
	logic               trim_skip_next;
	logic               pflag_reg;
	logic               pflag_next;
	logic [1:0]         alm_flag;
	logic [1:0]         alm_flag_next;
	rcf_pkg::rcf_snap_s snap_o_reg;

	// ----------------------------------------
	// Register side handshake
	// ----------------------------------------
	// Acknowledge edge from the oscillator side
	wire hs_idle  = hs_reg == rcf_pkg::RCF_ST_IDLE;
	wire ack_edge = ack_s2_reg ^ ack_seen_reg;
	assign reg_ready_out = hs_idle;

	// Request issued every idle cycle, write or not
	always_comb begin
		case (hs_reg)
			rcf_pkg::RCF_ST_IDLE: hs_next = rcf_pkg::RCF_ST_WAIT;
			rcf_pkg::RCF_ST_WAIT: begin
				hs_next = ack_edge ? rcf_pkg::RCF_ST_IDLE
					: rcf_pkg::RCF_ST_WAIT;
			end
			default: hs_next = rcf_pkg::RCF_ST_IDLE;
		endcase
	end

	// State and request toggle
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			hs_reg      <= rcf_pkg::RCF_ST_IDLE;
			req_tgl_reg <= 1'b0;
		end else begin
			hs_reg      <= hs_next;
			req_tgl_reg <= req_tgl_reg ^ hs_idle;
		end
	end

	// Held request, stable while the toggle crosses
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			hold_addr_reg <= 4'h0;
			hold_data_reg <= 8'h00;
			hold_wr_reg   <= 1'b0;
		end else if (hs_idle) begin
			hold_addr_reg <= reg_addr_in;
			hold_data_reg <= reg_wdata_in;
			hold_wr_reg   <= reg_wr_in;
		end
	end

	// Acknowledge synchroniser
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ack_s1_reg   <= 1'b0;
			ack_s2_reg   <= 1'b0;
			ack_seen_reg <= 1'b0;
		end else begin
			ack_s1_reg   <= req_s3_reg;
			ack_s2_reg   <= ack_s1_reg;
			ack_seen_reg <= ack_s2_reg;
		end
	end

	// Snapshot capture, source held since ack
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			snap_m_reg <= '0;
		else if (!hs_idle && ack_edge)
			snap_m_reg <= snap_o_reg;
	end

	// Read select, unmapped reads zero
	assign rd_mux =
		(reg_addr_in == `RCF_OFS_SEC)  ? snap_m_reg.t.sec  :
		(reg_addr_in == `RCF_OFS_MIN)  ? snap_m_reg.t.min  :
		(reg_addr_in == `RCF_OFS_HOUR) ? snap_m_reg.t.hour :
		(reg_addr_in == `RCF_OFS_WDAY) ? snap_m_reg.t.wday :
		(reg_addr_in == `RCF_OFS_MDAY) ? snap_m_reg.t.mday :
		(reg_addr_in == `RCF_OFS_MON)  ?
			(snap_m_reg.t.mon | {snap_m_reg.t.cent, 7'h00}) :
		(reg_addr_in == `RCF_OFS_YEAR) ? snap_m_reg.t.year :
		(reg_addr_in == `RCF_OFS_TRIM) ? snap_m_reg.trim   :
		(reg_addr_in == `RCF_OFS_FLAGS) ?
			{5'h00, snap_m_reg.flags} : 8'h00;

	// Read data register
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rd_mux;
	end
	assign reg_rdata_out = rdata_reg;

	// ----------------------------------------
	// Oscillator side crossing
	// ----------------------------------------
	// Request toggle and halt pin synchronisers
	always_ff @(posedge osc_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			req_s1_reg  <= 1'b0;
			req_s2_reg  <= 1'b0;
			req_s3_reg  <= 1'b0;
			halt_s1_reg <= 1'b0;
			halt_s2_reg <= 1'b0;
			halt_s3_reg <= 1'b0;
		end else begin
			req_s1_reg  <= req_tgl_reg;
			req_s2_reg  <= req_s1_reg;
			req_s3_reg  <= req_s2_reg;
			halt_s1_reg <= osc_halt_flag_in;
			halt_s2_reg <= halt_s1_reg;
			halt_s3_reg <= halt_s2_reg;
		end
	end

	// Write decode
	wire       req_edge  = req_s2_reg ^ req_s3_reg;
	wire       halt_rise = halt_s2_reg & ~halt_s3_reg;
	wire       wr_now    = req_edge & hold_wr_reg;
	wire [7:0] wd        = hold_data_reg;
	wire [3:0] wa        = hold_addr_reg;
	wire wr_sec   = wr_now && wa == `RCF_OFS_SEC;
	wire wr_min   = wr_now && wa == `RCF_OFS_MIN;
	wire wr_hour  = wr_now && wa == `RCF_OFS_HOUR;
	wire wr_wday  = wr_now && wa == `RCF_OFS_WDAY;
	wire wr_mday  = wr_now && wa == `RCF_OFS_MDAY;
	wire wr_mon   = wr_now && wa == `RCF_OFS_MON;
	wire wr_year  = wr_now && wa == `RCF_OFS_YEAR;
	wire wr_trim  = wr_now && wa == `RCF_OFS_TRIM;
	wire wr_flags = wr_now && wa == `RCF_OFS_FLAGS;

	// ----------------------------------------
	// Prescaler and trim
	// ----------------------------------------
	// Trim amount and trimmed second length
	wire [5:0]  mag      = trim_reg[5:0];
	wire        no_trim  = mag[5:1] == 5'h00;
	wire        trim_sec = time_reg.sec == `RCF_ZERO ||
		time_reg.sec == `RCF_TRIM_S20 ||
		time_reg.sec == `RCF_TRIM_S40;
	wire        trim_now = trim_on_reg && !trim_skip_reg &&
		trim_sec && !no_trim;
	wire [15:0] adj_up   = {9'h000, mag - 6'h01, 1'b0};
	wire [15:0] adj_dn   = {8'h00, {1'b0, ~mag} + 7'h01, 1'b0};
	wire [15:0] cnt_last = !trim_now ? CNT_PLAIN :
		trim_reg[`RCF_TRIM_DIR] ? CNT_PLAIN - adj_dn
		: CNT_PLAIN + adj_up;
	wire        tick     = pre_reg == cnt_last;

	// Prescaler restarts on a seconds write
	assign pre_next = (tick || wr_sec) ? 16'h0000
		: pre_reg + 16'h0001;

	// Trim register, halt beats a write
	assign trim_next = halt_rise ? 8'h00
		: wr_trim ? (wd & `RCF_MASK_TRIM) : trim_reg;
	assign trim_on_next = halt_rise ? 1'b0
		: wr_trim ? 1'b1 : trim_on_reg;
	assign trim_skip_next = wr_trim ? 1'b1
		: tick ? 1'b0 : trim_skip_reg;

	// Prescaler and trim state
	always_ff @(posedge osc_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pre_reg       <= 16'h0000;
			trim_reg      <= 8'h00;
			trim_on_reg   <= 1'b0;
			trim_skip_reg <= 1'b0;
		end else begin
			pre_reg       <= pre_next;
			trim_reg      <= trim_next;
			trim_on_reg   <= trim_on_next;
			trim_skip_reg <= trim_skip_next;
		end
	end

	// ----------------------------------------
	// Time and calendar counters
	// ----------------------------------------
	rcf_cal_if cal ();
	assign cal.h24 = hour24_mode_in;
	assign cal.cur = time_reg;

	// Whole carry chain in one step
	rcf_cal_step u_step (
		.cal (cal)
	);
	assign time_base = tick ? cal.nxt : time_reg;

	// Writes replace their field, masked except the year
	always_comb begin
		time_next = time_base;
		if (wr_sec)
			time_next.sec = wd & `RCF_MASK_SEC;
		if (wr_min)
			time_next.min = wd & `RCF_MASK_MIN;
		if (wr_hour)
			time_next.hour = wd & `RCF_MASK_HOUR;
		if (wr_wday)
			time_next.wday = wd & `RCF_MASK_WDAY;
		if (wr_mday)
			time_next.mday = wd & `RCF_MASK_MDAY;
		if (wr_mon) begin
			time_next.mon  = wd & `RCF_MASK_MON;
			time_next.cent = wd[`RCF_BIT_CENT];
		end
		if (wr_year)
			time_next.year = wd;
	end

	// Counter state
	always_ff @(posedge osc_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			time_reg <= TIME_RST;
		else
			time_reg <= time_next;
	end

	// ----------------------------------------
	// Interrupt flags
	// ----------------------------------------
	// Periodic flag, set wins over a clearing write
	assign pflag_next = !periodic_level_mode_in ? periodic_assert_in
		: periodic_assert_in ? 1'b1
		: (wr_flags && !wd[`RCF_BIT_PFLAG]) ? 1'b0
		: pflag_reg;

	// Periodic flag state
	always_ff @(posedge osc_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			pflag_reg <= 1'b0;
		else
			pflag_reg <= pflag_next;
	end
	assign periodic_irq_pin_n_out = ~pflag_reg;

	// Alarm zero daily, alarm one weekly, bit = index
	wire [1:0] alm_en = {weekly_alarm_enable_in, daily_alarm_enable_in};
	wire [1:0] alm_match = {weekly_alarm_match_in, daily_alarm_match_in};

	genvar g;
	for (g = 0; g < 2; g++) begin : g_alarm
		logic       match_d_reg;
		logic [1:0] dly_reg;
		logic       flag_reg;
		wire        hit  = alm_match[g] & ~match_d_reg;
		wire        done = dly_reg == 2'h1;

		// Delay after match, then set; set wins
		assign alm_flag_next[g] = !alm_en[g] ? 1'b0
			: done ? 1'b1
			: (wr_flags && !wd[g]) ? 1'b0
			: flag_reg;

		// Match edge, delay count, flag
		always_ff @(posedge osc_clk_in or posedge sys_rst_in) begin
			if (sys_rst_in) begin
				match_d_reg <= 1'b0;
				dly_reg     <= 2'h0;
				flag_reg    <= 1'b0;
			end else begin
				match_d_reg <= alm_match[g];
				dly_reg     <= hit ? ALM_DLY
					: (dly_reg != 2'h0) ? dly_reg - 2'h1 : dly_reg;
				flag_reg    <= alm_flag_next[g];
			end
		end
		assign alm_flag[g] = flag_reg;
	end

	// Pins follow their flags
	assign daily_alarm_pin_n_out  = ~alm_flag[0];
	assign weekly_alarm_pin_n_out = ~alm_flag[1];

	// ----------------------------------------
	// Snapshot toward the register side
	// ----------------------------------------
	// Loaded with post-write values on each request
	always_ff @(posedge osc_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			snap_o_reg <= '0;
		else if (req_edge)
			snap_o_reg <= '{t: time_next, trim: trim_next,
				flags: {pflag_next, alm_flag_next}};
	end
endmodule
`default_nettype wire

// >>> verification/rcf_rtc_core_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcf_params.svh"
module rcf_rtc_core_asserts (
	// Clocks and reset
	input wire logic       mclk_in,
	input wire logic       osc_clk_in,
	input wire logic       sys_rst_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_ready_out,
	input wire logic [7:0] reg_rdata_out,
	// Events and pins
	input wire logic       periodic_level_mode_in,
	input wire logic       periodic_assert_in,
	input wire logic       weekly_alarm_enable_in,
	input wire logic       daily_alarm_enable_in,
	input wire logic       weekly_alarm_match_in,
	input wire logic       daily_alarm_match_in,
	input wire logic       periodic_irq_pin_n_out,
	input wire logic       weekly_alarm_pin_n_out,
	input wire logic       daily_alarm_pin_n_out
);
	// Pins follow their events on the link clock
	a_weekly_alarm_set: assert property (@(posedge osc_clk_in)
		disable iff (sys_rst_in) weekly_alarm_enable_in &&
		$rose(weekly_alarm_match_in) |-> ##[2:3] !weekly_alarm_pin_n_out)
		else $error("weekly alarm pin missed its match");
	a_daily_alarm_set: assert property (@(posedge osc_clk_in)
		disable iff (sys_rst_in) daily_alarm_enable_in &&
		$rose(daily_alarm_match_in) |-> ##[2:3] !daily_alarm_pin_n_out)
		else $error("daily alarm pin missed its match");
	a_daily_alarm_off: assert property (@(posedge osc_clk_in)
		disable iff (sys_rst_in) !daily_alarm_enable_in &&
		!$past(daily_alarm_enable_in, 2) |-> daily_alarm_pin_n_out)
		else $error("disabled daily alarm pin low");
	a_periodic_level_set: assert property (@(posedge osc_clk_in)
		disable iff (sys_rst_in) periodic_level_mode_in &&
		periodic_assert_in |-> ##[1:2] !periodic_irq_pin_n_out)
		else $error("periodic pin not low after event");
	// Read data ranges and unused bits
	a_secmin_bcd: assert property (@(posedge mclk_in)
		disable iff (sys_rst_in)
		reg_addr_in inside {`RCF_OFS_SEC, `RCF_OFS_MIN} |=>
		reg_rdata_out <= 8'h59 && reg_rdata_out[3:0] <= 4'h9)
		else $error("seconds or minutes out of range");
	a_hour_day_bits: assert property (@(posedge mclk_in)
		disable iff (sys_rst_in)
		reg_addr_in inside {`RCF_OFS_HOUR, `RCF_OFS_MDAY} |=>
		reg_rdata_out[7:6] == 2'h0 && reg_rdata_out[3:0] <= 4'h9)
		else $error("hour or day field out of range");
	a_month_range: assert property (@(posedge mclk_in)
		disable iff (sys_rst_in) reg_addr_in == `RCF_OFS_MON |=>
		reg_rdata_out[6:0] inside {[7'h01:7'h09], [7'h10:7'h12]})
		else $error("month out of range");
	a_weekday_range: assert property (@(posedge mclk_in)
		disable iff (sys_rst_in) reg_addr_in == `RCF_OFS_WDAY |=>
		reg_rdata_out <= 8'h06)
		else $error("weekday out of range");
	a_trim_msb_zero: assert property (@(posedge mclk_in)
		disable iff (sys_rst_in) reg_addr_in == `RCF_OFS_TRIM |=>
		!reg_rdata_out[7])
		else $error("trim top bit set");
	a_unmapped_zero: assert property (@(posedge mclk_in)
		disable iff (sys_rst_in) reg_addr_in inside {[4'h8:4'hE]} |=>
		reg_rdata_out == 8'h00)
		else $error("unmapped slot not zero");
	a_trip_ends: assert property (@(posedge mclk_in)
		disable iff (sys_rst_in) !reg_ready_out |-> ##[1:30] reg_ready_out)
		else $error("register trip never ended");
	// Main scenarios reached
	c_write_taken: cover property (@(posedge mclk_in)
		reg_wr_in && reg_ready_out);
	c_weekly_alarm: cover property (@(posedge osc_clk_in)
		!weekly_alarm_pin_n_out);
	c_periodic: cover property (@(posedge osc_clk_in)
		!periodic_irq_pin_n_out);
endmodule
bind rcf_rtc_core rcf_rtc_core_asserts u_chk (.*);
`default_nettype wire

// >>> verification/rcf_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module rcf_host_model (
	// Clock
	input  wire logic       mclk_in,
	// Register port toward the device
	output logic [3:0]      reg_addr_out,
	output logic            reg_wr_out,
	output logic [7:0]      reg_wdata_out,
	input  wire logic       reg_ready_in,
	input  wire logic [7:0] reg_rdata_in
);
	// Bus idle at time zero, parked on an unmapped slot
	initial begin
		reg_addr_out = 4'h8;
		reg_wr_out = 1'b0;
		reg_wdata_out = 8'h00;
	end
	// Write held until taken, then wait out the trip
	task automatic write(input logic [3:0] a, input logic [7:0] d,
		output bit ok);
		int n;
		n = 0;
		@(posedge mclk_in);
		reg_addr_out <= a;
		reg_wdata_out <= d;
		reg_wr_out <= 1'b1;
		do begin
			@(posedge mclk_in);
			n++;
		end while (!reg_ready_in && n < 40);
		reg_wr_out <= 1'b0;
		reg_wdata_out <= ~d;
		do begin
			@(posedge mclk_in);
			n++;
		end while (!reg_ready_in && n < 80);
		ok = n < 80;
	endtask
	// Data shows one edge after the address
	task automatic peek(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk_in);
		reg_addr_out <= a;
		repeat (2) @(posedge mclk_in);
		d = reg_rdata_in;
	endtask
endmodule
`default_nettype wire

// >>> verification/rcf_rtc_core_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcf_params.svh"
module rcf_rtc_core_test;
	// Stimulus and observed signals
	logic       mclk_in = 1'b0;
	logic       osc_clk_in = 1'b0;
	logic       sys_rst_in = 1'b1;
	logic       hour24_mode_in = 1'b1;
	logic       periodic_level_mode_in = 1'b1;
	logic       periodic_assert_in = 1'b0;
	logic       osc_halt_flag_in = 1'b0;
	logic [1:0] en = 2'b00;
	logic [1:0] mt = 2'b00;
	wire logic  weekly_alarm_enable_in = en[1];
	wire logic  daily_alarm_enable_in = en[0];
	wire logic  weekly_alarm_match_in = mt[1];
	wire logic  daily_alarm_match_in = mt[0];
	logic [3:0] reg_addr_in;
	logic       reg_wr_in;
	logic [7:0] reg_wdata_in;
	logic       reg_ready_out;
	logic [7:0] reg_rdata_out;
	logic       periodic_irq_pin_n_out;
	logic       weekly_alarm_pin_n_out;
	logic       daily_alarm_pin_n_out;
	wire logic [1:0] pins = {weekly_alarm_pin_n_out, daily_alarm_pin_n_out};
	int         mismatches = 0;
	int         compares = 0;
	bit         ok;
	logic [7:0] v;
	// Start points: 24h, hour, weekday, day, month, year
	logic [7:0] tbl [3][6] = '{'{8'h01, 8'h23, 8'h06, 8'h31, 8'h12, 8'h99},
		'{8'h00, 8'h31, 8'h02, 8'h28, 8'h02, 8'h04},
		'{8'h01, 8'h23, 8'h03, 8'h28, 8'h02, 8'h05}};
	// Main clock period 10, link clock period 6
	always #5 mclk_in = ~mclk_in;
	always #3 osc_clk_in = ~osc_clk_in;
	rcf_rtc_core u_dut (.*);
	rcf_host_model u_host (
		.mclk_in       (mclk_in),
		.reg_addr_out  (reg_addr_in),
		.reg_wr_out    (reg_wr_in),
		.reg_wdata_out (reg_wdata_in),
		.reg_ready_in  (reg_ready_out),
		.reg_rdata_in  (reg_rdata_out)
	);
	// Compare and count
	task automatic check(input string what, input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Counts, verdict, end of run
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Register write, a hang ends the run
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		u_host.write(a, d, ok);
		if (!ok) begin
			mismatches++;
			print_verdict();
		end
	endtask
	// Ignored write refreshes the view, then read
	task automatic rd(input logic [3:0] a, input logic [7:0] e, string w);
		wr(4'h8, 8'hFF);
		u_host.peek(a, v);
		check(w, v, e);
	endtask
	task automatic osc(input int n);
		repeat (n) @(posedge osc_clk_in);
	endtask
	// Month length, leap years by BCD year
	function automatic logic [7:0] last_day(input logic [7:0] m, y);
		if (m == 8'h02)
			return ((y[7:4] * 10 + y[3:0]) % 4 == 0) ? 8'h29 : 8'h28;
		return (m inside {8'h04, 8'h06, 8'h09, 8'h11}) ? 8'h30 : 8'h31;
	endfunction
	// Main sequence
	initial begin
		logic [7:0] h, w, d, m, y, l, em;
		v = $urandom(49);
		repeat (6) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		repeat (6) @(posedge mclk_in);
		for (int a = 0; a < 8; a++)
			rd(4'(a), (a == 4 || a == 5) ? 8'h01 : 8'h00, "reset value");
		rd(4'hA, 8'h00, "unmapped");
		$display("reset test done");
		v = $urandom;
		wr(`RCF_OFS_TRIM, v);
		rd(`RCF_OFS_TRIM, v & `RCF_MASK_TRIM, "trim");
		@(posedge osc_clk_in);
		osc_halt_flag_in <= 1'b1;
		osc(6);
		rd(`RCF_OFS_TRIM, 8'h00, "trim after halt");
		osc_halt_flag_in <= 1'b0;
		$display("trim test done");
		// Each alarm: set, write one, write zero
		for (int i = 1; i >= 0; i--) begin
			@(posedge osc_clk_in);
			en[i] <= 1'b1;
			osc(3);
			mt[i] <= 1'b1;
			osc(4);
			mt[i] <= 1'b0;
			check("alarm pin", {7'h00, pins[i]}, 8'h00);
			rd(`RCF_OFS_FLAGS, 8'h01 << i, "alarm flag");
			wr(`RCF_OFS_FLAGS, 8'h07);
			rd(`RCF_OFS_FLAGS, 8'h01 << i, "flag after one");
			wr(`RCF_OFS_FLAGS, ~(8'h01 << i));
			rd(`RCF_OFS_FLAGS, 8'h00, "flag after zero");
			check("released pin", {7'h00, pins[i]}, 8'h01);
		end
		@(posedge osc_clk_in);
		mt[0] <= 1'b1;
		osc(4);
		en[0] <= 1'b0;
		mt[0] <= 1'b0;
		osc(3);
		rd(`RCF_OFS_FLAGS, 8'h00, "disabled flag");
		check("disabled pin", {7'h00, pins[0]}, 8'h01);
		$display("alarm test done");
		// Periodic flag in level mode, then pulse mode
		for (int p = 1; p >= 0; p--) begin
			@(posedge osc_clk_in);
			periodic_level_mode_in <= p[0];
			periodic_assert_in <= 1'b1;
			osc(p ? 1 : 4);
			periodic_assert_in <= !p[0];
			osc(3);
			check("periodic pin", {7'h00, periodic_irq_pin_n_out}, 8'h00);
			rd(`RCF_OFS_FLAGS, 8'h04, "periodic flag");
			wr(`RCF_OFS_FLAGS, 8'h03);
			rd(`RCF_OFS_FLAGS, p ? 8'h00 : 8'h04, "periodic clear");
			check("periodic off", {7'h00, periodic_irq_pin_n_out}, 8'(p));
		end
		periodic_assert_in <= 1'b0;
		$display("periodic test done");
		// Last second of a day, one full second later
		for (int k = 0; k < 3; k++) begin
			h = tbl[k][1];
			w = tbl[k][2];
			d = tbl[k][3];
			m = tbl[k][4];
			y = tbl[k][5];
			@(posedge osc_clk_in);
			hour24_mode_in <= tbl[k][0][0];
			wr(`RCF_OFS_SEC, 8'h00);
			wr(`RCF_OFS_YEAR, y);
			wr(`RCF_OFS_MON, m);
			wr(`RCF_OFS_MDAY, d);
			wr(`RCF_OFS_WDAY, w);
			wr(`RCF_OFS_HOUR, h);
			wr(`RCF_OFS_MIN, 8'h59);
			wr(`RCF_OFS_SEC, 8'h59);
			repeat (19400) @(posedge mclk_in);
			rd(`RCF_OFS_SEC, 8'h59, "second before tick");
			repeat (500) @(posedge mclk_in);
			l = last_day(m, y);
			em = (d == l) ? ((m == 8'h12) ? 8'h01 : m + 8'h01) : m;
			em[7] = d == l && m == 8'h12 && y == 8'h99;
			rd(`RCF_OFS_SEC, 8'h00, "seconds");
			rd(`RCF_OFS_MIN, 8'h00, "minutes");
			rd(`RCF_OFS_HOUR, tbl[k][0][0] ? 8'h00 : 8'h12, "hours");
			rd(`RCF_OFS_WDAY, w == 8'h06 ? 8'h00 : w + 8'h01, "wday");
			rd(`RCF_OFS_MDAY, d == l ? 8'h01 : d + 8'h01, "mday");
			rd(`RCF_OFS_MON, em, "month");
			rd(`RCF_OFS_YEAR, em[7] ? 8'h00 : y, "year");
			$display("calendar test %0d done", k);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
